// ==== verilog/wdt_sleep_pkg.sv ====
// Constants, states and carrier types shared by the watchdog and sleep controller.
package wdt_sleep_pkg;
	localparam int ADDR_W = 16;
	localparam int PC_W = 13;
	localparam int IRQ_W = 8;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 16'h0003;
	localparam logic [ADDR_W-1:0] IDX_CAUSE = 16'h0004;
	localparam logic [ADDR_W-1:0] IDX_OPTION = 16'h0081;
	localparam logic [ADDR_W-1:0] IDX_CONFIG = 16'h2007;
	localparam int OPT_PSA_BIT = 3;
	localparam int OPT_RATIO_LSB = 0;
	localparam int RATIO_W = 3;
	localparam int CFG_WATCHDOG_FUSE_ENABLE_BIT = 2;
	localparam int STAT_PD_BIT = 3;
	localparam int STAT_TO_BIT = 4;
	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
	localparam int CLK_MHZ = 100;
	localparam int WDT_PERIOD_MS = 18;
	localparam int WDT_RESET_NS = 100;
	localparam int WDT_RESET_CYCLES = (WDT_RESET_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] CAUSE_POWER_UP = 3'h0;
	localparam logic [2:0] CAUSE_WDT_RESET = 3'h1;
	localparam logic [2:0] CAUSE_WDT_WAKE = 3'h2;
	localparam logic [2:0] CAUSE_IRQ_WAKE = 3'h3;
	localparam logic [2:0] CAUSE_MASTER_RESET = 3'h4;

	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_WAKE = 4'b0100,
		ST_VECTOR = 4'b1000
	} state_t;

	typedef struct packed {
		logic kick;
		logic sleep;
		logic globalIrqEnable;
	} core_cmd_t;

	typedef struct packed {
		logic prefetchNext;
		logic resumeExec;
		logic clearGie;
		logic pushReturn;
		logic loadVector;
	} core_ctl_t;

	function automatic logic [ADDR_W-1:0] regByteAddr(input logic [ADDR_W-1:0] idx);
		regByteAddr = {idx[ADDR_W-3:0], 2'b00};
	endfunction : regByteAddr
endpackage : wdt_sleep_pkg

// ==== verilog/wdt_counter.sv ====
// Watchdog prescaler and period counter stepped by the watchdog oscillator ticks.
`timescale 1ns/10ps
module wdt_counter
	import wdt_sleep_pkg::*;
#(
	parameter int BASE_TICKS = 18000
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic oscTick,
	input wire logic clearCount,
	input wire logic enable,
	input wire logic prescalerAssigned,
	input wire logic [RATIO_W-1:0] ratio,
	output logic expired
);
	localparam int CNT_W = $clog2(BASE_TICKS + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(BASE_TICKS - 1);

	logic [6:0] preCount;
	logic [CNT_W-1:0] baseCount;
	logic preDone;
	logic [6:0] preLast;

	assign preLast = 7'(({7'h00, 1'b1} << ratio) - 8'h01);
	assign preDone = !prescalerAssigned || (preCount == preLast);

	// The prescaler is shared with another timer, so a watchdog clear touches it only when it is assigned here.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			preCount <= 7'h00;
		end else if (clearCount && prescalerAssigned) begin
			preCount <= 7'h00;
		end else if (enable && oscTick && prescalerAssigned) begin
			preCount <= preDone ? 7'h00 : preCount + 7'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			baseCount <= '0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (clearCount || !enable) begin
				baseCount <= '0;
			end else if (oscTick && preDone) begin
				baseCount <= (baseCount == LAST) ? '0 : baseCount + CNT_W'(1);
				expired <= (baseCount == LAST);
			end
		end
	end

	AST_CLEAR_ZEROES: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clearCount |=> baseCount == '0 && !expired)
		else $error("Watchdog clear did not zero the counter.");
	AST_NO_EXPIRY_DISABLED: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!enable |=> !expired)
		else $error("Disabled watchdog expired.");
endmodule : wdt_counter

// ==== verilog/wdt_sleep_ctrl.sv ====
// Watchdog timer and power-down controller with its AXI4-Lite register port.
//
// Summary of operation
// - Watchdog counts ticks of its own free-running oscillator, also during sleep.
// - Watchdog expiry in normal operation issues a watchdog-classified device reset.
// - Watchdog expiry during sleep wakes the device and execution continues.
// - Configuration fuse bit disables the watchdog when clear, enables when set.
// - Unscaled watchdog period is nominally eighteen milliseconds of its oscillator.
// - Option register assigns the shared prescaler and selects ratio up to 1:128.
// - Kick or sleep clears the watchdog, and the prescaler when assigned.
// - Clearing zeroes the prescaler count only; assignment and ratio stay.
// - A watchdog expiry clears the timeout flag in every state but the wake state.
// - Entering sleep clears power-down flag, sets timeout flag, stops oscillator driver.
// - During sleep all pins hold their previous drive state.
// - Master reset, watchdog or enabled interrupt ends sleep; only master reset resets.
// - Power-down flag is set at power-up and cleared only by sleep.
// - An interrupt wakes only with its own enable set, regardless of global enable.
// - After interrupt wake, run next instruction, then vector if global enable set.
// - Sleep prefetches the following instruction for execution on wake.
// - Sleep with an enabled interrupt already pending acts as a no-op.
// - Interrupt during or after sleep completes the sleep, then wakes at once.
// - Only sources running without core clocks may wake the device from sleep.
// - Interrupt response clears global enable, pushes return address, loads the vector.
`timescale 1ns/10ps
module wdt_sleep_ctrl
	import wdt_sleep_pkg::*;
#(
	parameter int WDT_OSC_KHZ = 1000,
	parameter int WDT_BASE_TICKS = WDT_PERIOD_MS * WDT_OSC_KHZ,
	parameter logic [IRQ_W-1:0] WAKE_CAPABLE = 8'hff
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wdtOscPin,
	input wire logic master_reset_pin_n,
	input wire logic [7:0] configWordPin,
	input wire core_cmd_t coreCmd,
	input wire logic [IRQ_W-1:0] irqEnable,
	input wire logic [IRQ_W-1:0] irqFlag,
	output core_ctl_t coreCtl,
	output logic [PC_W-1:0] vectorAddr,
	output logic wdtResetOut,
	output logic masterResetOut,
	output logic oscDriverOn,
	output logic ioHold
);
	////////////////////////////////////////////////////////////////////////////////
	state_t state;
	logic [2:0] oscSync;
	logic [2:0] mclrSync;
	logic oscLevel;
	logic oscTick;
	logic mclrActive;
	logic wdtExpired;
	logic [7:0] optionReg;
	logic [7:0] configReg;
	logic configLoaded;
	logic watchdogFuse;
	logic statusTo;
	logic statusPd;
	logic [2:0] resetCause;
	logic [7:0] resetHold;
	logic irqPending;
	logic wakeIrq;
	logic sleepEnter;
	logic sleepNop;
	logic wdtClear;
	logic wakeByIrq;

	assign watchdogFuse = configReg[CFG_WATCHDOG_FUSE_ENABLE_BIT];
	assign irqPending = |(irqEnable & irqFlag);
	assign wakeIrq = |(irqEnable & irqFlag & WAKE_CAPABLE);
	assign sleepEnter = state == ST_RUN && coreCmd.sleep && !irqPending && !mclrActive && !wdtResetOut && !wdtExpired;
	assign sleepNop = state == ST_RUN && coreCmd.sleep && irqPending;
	assign wdtClear = (state == ST_RUN && coreCmd.kick) || sleepEnter || wdtResetOut || mclrActive;

	////////////////////////////////////////////////////////////////////////////////
	// Pin inputs take three stages; a change counts once the last two agree, so the first is never decoded.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			oscSync <= 3'h0;
			mclrSync <= 3'h7;
			oscLevel <= 1'b0;
			mclrActive <= 1'b0;
		end else begin
			oscSync <= {oscSync[1:0], wdtOscPin};
			mclrSync <= {mclrSync[1:0], master_reset_pin_n};
			if (oscSync[1] == oscSync[2]) begin
				oscLevel <= oscSync[2];
			end
			if (mclrSync[1] == mclrSync[2]) begin
				mclrActive <= !mclrSync[2];
			end
		end
	end

	assign oscTick = (oscSync[1] == oscSync[2]) && oscSync[2] && !oscLevel;

	wdt_counter #(
		.BASE_TICKS(WDT_BASE_TICKS)
	) u_wdt_counter (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.oscTick(oscTick),
		.clearCount(wdtClear),
		.enable(watchdogFuse),
		.prescalerAssigned(optionReg[OPT_PSA_BIT]),
		.ratio(optionReg[OPT_RATIO_LSB +: RATIO_W]),
		.expired(wdtExpired)
	);

	////////////////////////////////////////////////////////////////////////////////
	// The fuse word is caught after reset release, never through the asynchronous reset.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			configReg <= CONFIG_RESET;
			configLoaded <= 1'b0;
		end else if (!configLoaded) begin
			configReg <= configWordPin;
			configLoaded <= 1'b1;
		end
	end

	// Expiry outranks a kick in the same cycle so a late kick cannot hide a time-out.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			statusTo <= 1'b1;
			statusPd <= 1'b1;
		end else if (wdtExpired && state != ST_WAKE) begin
			statusTo <= 1'b0;
		end else if (sleepEnter) begin
			statusTo <= 1'b1;
			statusPd <= 1'b0;
		end else if (state == ST_RUN && coreCmd.kick) begin
			statusTo <= 1'b1;
			statusPd <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			resetHold <= 8'h00;
			wdtResetOut <= 1'b0;
			masterResetOut <= 1'b0;
		end else begin
			masterResetOut <= mclrActive;
			if (wdtExpired && state == ST_RUN && !mclrActive) begin
				resetHold <= 8'(WDT_RESET_CYCLES - 1);
				wdtResetOut <= 1'b1;
			end else if (resetHold != 8'h00) begin
				resetHold <= resetHold - 8'h01;
			end else begin
				wdtResetOut <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_RUN;
			wakeByIrq <= 1'b0;
			resetCause <= CAUSE_POWER_UP;
		end else if (mclrActive) begin
			state <= ST_RUN;
			resetCause <= CAUSE_MASTER_RESET;
		end else begin
			case (state)
				ST_RUN: begin
					if (wdtExpired) begin
						resetCause <= CAUSE_WDT_RESET;
					end else if (sleepEnter) begin
						state <= ST_SLEEP;
					end else if (coreCmd.globalIrqEnable && irqPending && !wdtResetOut) begin
						state <= ST_VECTOR;
					end
				end
				ST_SLEEP: begin
					if (wdtExpired) begin
						state <= ST_WAKE;
						wakeByIrq <= 1'b0;
						resetCause <= CAUSE_WDT_WAKE;
					end else if (wakeIrq) begin
						state <= ST_WAKE;
						wakeByIrq <= 1'b1;
						resetCause <= CAUSE_IRQ_WAKE;
					end
				end
				ST_WAKE: begin
					state <= (wakeByIrq && coreCmd.globalIrqEnable) ? ST_VECTOR : ST_RUN;
				end
				ST_VECTOR: begin
					state <= ST_RUN;
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			coreCtl <= '0;
			vectorAddr <= '0;
			oscDriverOn <= 1'b1;
			ioHold <= 1'b0;
		end else begin
			coreCtl.prefetchNext <= sleepEnter || sleepNop;
			coreCtl.resumeExec <= state == ST_WAKE && !mclrActive;
			coreCtl.clearGie <= state == ST_VECTOR && !mclrActive;
			coreCtl.pushReturn <= state == ST_VECTOR && !mclrActive;
			coreCtl.loadVector <= state == ST_VECTOR && !mclrActive;
			vectorAddr <= (state == ST_VECTOR) ? IRQ_VECTOR : '0;
			if (sleepEnter) begin
				oscDriverOn <= 1'b0;
				ioHold <= 1'b1;
			end else if (state != ST_RUN || mclrActive) begin
				oscDriverOn <= !(state == ST_SLEEP && !wdtExpired && !wakeIrq && !mclrActive);
				ioHold <= state == ST_SLEEP && !wdtExpired && !wakeIrq && !mclrActive;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One write and one read are served at a time; address and data may arrive in either order.
	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			wStrb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			optionReg <= OPTION_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (awHeld && wHeld && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= RESP_SLVERR;
				if (awAddr == regByteAddr(IDX_OPTION)) begin
					s_axi_bresp <= RESP_OKAY;
					if (wStrb[0]) begin
						optionReg <= wData[7:0];
					end
				end else if (awAddr == regByteAddr(IDX_CONFIG) || awAddr == regByteAddr(IDX_STATUS)
					|| awAddr == regByteAddr(IDX_CAUSE)) begin
					s_axi_bresp <= RESP_OKAY;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (wdtResetOut || mclrActive) begin
				optionReg <= OPTION_RESET;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			if (s_axi_araddr == regByteAddr(IDX_OPTION)) begin
				s_axi_rdata <= {24'h000000, optionReg};
			end else if (s_axi_araddr == regByteAddr(IDX_CONFIG)) begin
				s_axi_rdata <= {24'h000000, configReg};
			end else if (s_axi_araddr == regByteAddr(IDX_STATUS)) begin
				s_axi_rdata <= '0;
				s_axi_rdata[STAT_TO_BIT] <= statusTo;
				s_axi_rdata[STAT_PD_BIT] <= statusPd;
			end else if (s_axi_araddr == regByteAddr(IDX_CAUSE)) begin
				s_axi_rdata <= {29'h00000000, resetCause};
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	AST_SLEEP_FLAGS: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sleepEnter && !wdtExpired |=> !statusPd && statusTo && !oscDriverOn && state == ST_SLEEP)
		else $error("Sleep entry did not update flags and oscillator.");
	AST_SLEEP_NOP: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sleepNop && !wdtExpired && !mclrActive |=> state != ST_SLEEP && $stable(statusPd) && $stable(statusTo))
		else $error("Sleep with pending interrupt was not a no-op.");
	AST_WDT_RESET: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state == ST_RUN && wdtExpired && !mclrActive |=> wdtResetOut && !statusTo && resetCause == CAUSE_WDT_RESET)
		else $error("Watchdog expiry in run did not reset.");
	AST_WDT_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state == ST_SLEEP && wdtExpired && !mclrActive |=> state == ST_WAKE && !statusTo ##1 coreCtl.resumeExec)
		else $error("Watchdog expiry in sleep did not wake.");
	AST_IRQ_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state == ST_SLEEP && wakeIrq && !wdtExpired && !mclrActive |=> state == ST_WAKE ##1 coreCtl.resumeExec)
		else $error("Enabled interrupt did not wake.");
	AST_VECTOR_AFTER_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state == ST_WAKE && wakeByIrq && coreCmd.globalIrqEnable && !mclrActive
		|=> ##1 coreCtl.loadVector && coreCtl.clearGie && vectorAddr == IRQ_VECTOR)
		else $error("Interrupt wake with global enable did not vector.");
	AST_IO_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state == ST_SLEEP && $past(state) == ST_SLEEP |-> ioHold && !oscDriverOn)
		else $error("Pins not held during sleep.");
	AST_FUSE_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		configLoaded && !watchdogFuse |-> ##1 !wdtResetOut)
		else $error("Watchdog acted while fused off.");
	AST_MASTER_RESET: assert property (@(posedge clk_sys) disable iff (!reset_n)
		mclrActive |=> state == ST_RUN && masterResetOut && $stable(statusPd))
		else $error("Master reset not handled.");
endmodule : wdt_sleep_ctrl

// ==== testbench/core_model.sv ====
// Processor core stand-in that issues kick and sleep instructions and follows vectoring.
`timescale 1ns/10ps
module core_model
	import wdt_sleep_pkg::*;
(
	input wire logic clk_sys,
	input wire core_ctl_t coreCtl,
	output core_cmd_t coreCmd
);
	initial begin
		coreCmd = '0;
	end
	////////////////////////////////////////////////////////////////
	// Global enable drops in the cycle the vector is taken; a clock later the controller would vector again.
	always @(coreCtl.loadVector) begin
		if (coreCtl.loadVector === 1'h1) begin
			coreCmd.globalIrqEnable <= 1'h0;
		end
	end
	////////////////////////////////////////////////////////////////
	// The instruction fetched behind sleep is a no-op in this core, so wake-up runs nothing stray.
	task automatic issue(input logic isSleep);
		@(posedge clk_sys);
		coreCmd.sleep <= isSleep;
		coreCmd.kick <= !isSleep;
		@(posedge clk_sys);
		coreCmd.sleep <= 1'h0;
		coreCmd.kick <= 1'h0;
	endtask : issue
	task automatic setGie(input logic g);
		@(posedge clk_sys);
		coreCmd.globalIrqEnable <= g;
	endtask : setGie
endmodule : core_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the watchdog and sleep controller.
`timescale 1ns/10ps
module tb_top
	import wdt_sleep_pkg::*;
;
	localparam logic [ADDR_W-1:0] A_OPT = IDX_OPTION << 2;
	localparam logic [ADDR_W-1:0] A_CFG = IDX_CONFIG << 2;
	localparam logic [ADDR_W-1:0] A_STAT = IDX_STATUS << 2;
	localparam logic [ADDR_W-1:0] A_CAUSE = IDX_CAUSE << 2;
	localparam logic [ADDR_W-1:0] A_BAD = 16'h0100;
	localparam logic [31:0] TO_M = 32'h1 << STAT_TO_BIT;
	localparam logic [31:0] PD_M = 32'h1 << STAT_PD_BIT;
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic mrPin;
	logic [7:0] cfgPin;
	logic [IRQ_W-1:0] irqEn, irqFl;
	logic [2:0] oscCnt = '0;
	core_cmd_t coreCmd;
	core_ctl_t coreCtl;
	logic [PC_W-1:0] vectorAddr;
	logic wdtResetOut, masterResetOut, oscDriverOn, ioHold, sawWdtReset;
	logic [3:0] watch;
	int error_cnt = 0, n_checks = 0;
	////////////////////////////////////////////////////////////////
	// The watchdog oscillator is a slow free-running square wave, one tick every eight cycles.
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		oscCnt <= oscCnt + 3'h1;
	end
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sawWdtReset <= 1'h0;
		end else if (wdtResetOut === 1'h1) begin
			sawWdtReset <= 1'h1;
		end
	end
	assign watch = {coreCtl.loadVector, coreCtl.resumeExec, oscDriverOn, wdtResetOut};
	wdt_sleep_ctrl #(.WDT_BASE_TICKS(8), .WAKE_CAPABLE(8'hfd)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .wdtOscPin(oscCnt[2]), .master_reset_pin_n(mrPin), .configWordPin(cfgPin),
		.coreCmd(coreCmd), .irqEnable(irqEn), .irqFlag(irqFl), .coreCtl(coreCtl), .vectorAddr(vectorAddr),
		.wdtResetOut(wdtResetOut), .masterResetOut(masterResetOut), .oscDriverOn(oscDriverOn), .ioHold(ioHold));
	core_model core (.clk_sys(clk_sys), .coreCtl(coreCtl), .coreCmd(coreCmd));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic waitBit(input int b, output int n);
		n = 0;
		while (watch[b] !== 1'h1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
	endtask : waitBit
	task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
			if (awvalid && awready === 1'h1) awvalid <= 1'h0;
			if (wvalid && wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1 && n < 50);
		bready <= 1'h0;
		check({29'h0, bvalid, bresp}, {29'h0, 1'h1, er});
	endtask : axiWrite
	task automatic axiRead(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
			if (arvalid && arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1 && n < 50);
		rready <= 1'h0;
		check(rdata, exp);
		check({29'h0, rvalid, rresp}, {29'h0, 1'h1, er});
	endtask : axiRead
	task automatic doReset();
		reset_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'h1;
	endtask : doReset
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		axiRead(A_OPT, {24'h0, OPTION_RESET}, RESP_OKAY);
		wstrb <= 4'he;
		axiWrite(A_OPT, 8'h3c, RESP_OKAY);
		wstrb <= 4'hf;
		axiRead(A_OPT, {24'h0, OPTION_RESET}, RESP_OKAY);
		axiRead(A_STAT, TO_M | PD_M, RESP_OKAY);
		axiWrite(A_CFG, 8'h00, RESP_OKAY);
		axiRead(A_CFG, 32'h4, RESP_OKAY);
		axiRead(A_BAD, 32'h0, RESP_SLVERR);
		axiWrite(A_BAD, 8'h00, RESP_SLVERR);
	endtask : t_regs
	// Expiry is expected after m base periods; the window allows for tick phase and synchroniser delay.
	task automatic t_wdt(input logic [7:0] opt, input int m);
		int n;
		axiWrite(A_OPT, opt, RESP_OKAY);
		core.issue(1'h0);
		axiRead(A_OPT, {24'h0, opt}, RESP_OKAY);
		repeat (30) @(posedge clk_sys);
		core.issue(1'h0);
		waitBit(0, n);
		check(n >= 64 * m - 8 && n <= 64 * m + 20, 1'h1);
		n = 0;
		while (wdtResetOut === 1'h1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		check(n, WDT_RESET_CYCLES);
		axiRead(A_STAT, PD_M, RESP_OKAY);
		axiRead(A_CAUSE, {29'h0, CAUSE_WDT_RESET}, RESP_OKAY);
	endtask : t_wdt
	task automatic t_sleepWdt();
		int n;
		axiWrite(A_OPT, 8'h00, RESP_OKAY);
		core.issue(1'h0);
		core.issue(1'h1);
		@(negedge clk_sys);
		check(coreCtl.prefetchNext, 1'h1);
		check({oscDriverOn, ioHold}, 2'h1);
		axiRead(A_STAT, TO_M, RESP_OKAY);
		waitBit(2, n);
		check(n < 90 && wdtResetOut === 1'h0 && ioHold === 1'h0 && oscDriverOn === 1'h1, 1'h1);
		axiRead(A_STAT, 32'h0, RESP_OKAY);
		axiRead(A_CAUSE, {29'h0, CAUSE_WDT_WAKE}, RESP_OKAY);
	endtask : t_sleepWdt
	task automatic t_sleepIrq();
		int n;
		axiWrite(A_OPT, 8'h0f, RESP_OKAY);
		core.issue(1'h1);
		mrPin <= 1'h0;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		check({masterResetOut, oscDriverOn}, 2'h3);
		@(posedge clk_sys);
		mrPin <= 1'h1;
		repeat (6) @(posedge clk_sys);
		axiRead(A_CAUSE, {29'h0, CAUSE_MASTER_RESET}, RESP_OKAY);
		axiRead(A_STAT, TO_M, RESP_OKAY);
		irqFl <= 8'h03;
		core.setGie(1'h1);
		core.issue(1'h1);
		irqEn <= 8'h02;
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		check(ioHold, 1'h1);
		@(posedge clk_sys);
		irqEn <= 8'h01;
		waitBit(2, n);
		@(negedge clk_sys);
		check({coreCtl.clearGie, coreCtl.pushReturn, coreCtl.loadVector}, 3'h7);
		check(vectorAddr, IRQ_VECTOR);
		@(negedge clk_sys);
		check(coreCtl.loadVector, 1'h0);
		@(posedge clk_sys);
		irqEn <= 8'h00;
		core.issue(1'h1);
		irqEn <= 8'h01;
		waitBit(2, n);
		check(n < 10, 1'h1);
		@(negedge clk_sys);
		check(coreCtl.loadVector, 1'h0);
		axiRead(A_STAT, TO_M, RESP_OKAY);
		axiRead(A_CAUSE, {29'h0, CAUSE_IRQ_WAKE}, RESP_OKAY);
		core.issue(1'h0);
		core.issue(1'h1);
		@(negedge clk_sys);
		check({coreCtl.prefetchNext, oscDriverOn, ioHold}, 3'h6);
		axiRead(A_STAT, TO_M | PD_M, RESP_OKAY);
		irqEn <= 8'h00;
		irqFl <= 8'h00;
	endtask : t_sleepIrq
	task automatic t_fuseOff();
		axiRead(A_CFG, 32'h0, RESP_OKAY);
		axiWrite(A_OPT, 8'h00, RESP_OKAY);
		repeat (200) @(posedge clk_sys);
		check(sawWdtReset, 1'h0);
	endtask : t_fuseOff
	////////////////////////////////////////////////////////////////
	initial begin
		awaddr <= '0;
		araddr <= '0;
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		bready <= 1'h0;
		arvalid <= 1'h0;
		rready <= 1'h0;
		wdata <= '0;
		wstrb <= 4'hf;
		mrPin <= 1'h1;
		cfgPin <= 8'h04;
		irqEn <= '0;
		irqFl <= '0;
		doReset();
		t_regs();
		t_wdt(8'h00, 1);
		t_wdt(8'h02, 1);
		t_wdt(8'h09, 2);
		t_wdt(8'h0a, 4);
		t_sleepWdt();
		t_sleepIrq();
		@(posedge clk_sys);
		cfgPin <= 8'h00;
		doReset();
		t_fuseOff();
		stop_test();
	end
	// The whole sequence needs well under two thousand cycles; this limit of 20000 cycles is far beyond it.
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
endmodule : tb_top
